// ---- tpw_pkg.sv ----
// Shared constants and types for the six-channel PWM timer
package tpw_pkg;

    localparam int NCH = 6;
    localparam int NPAIR = 3;

    // Register byte offsets
    localparam logic [7:0] A_MAIN = 8'h00;
    localparam logic [7:0] A_CNT_HI = 8'h01;
    localparam logic [7:0] A_CNT_LO = 8'h02;
    localparam logic [7:0] A_MOD_HI = 8'h03;
    localparam logic [7:0] A_MOD_LO = 8'h04;
    localparam logic [7:0] A_CH_BASE = 8'h05;
    localparam logic [7:0] A_CH_STRIDE = 8'h03;
    localparam logic [7:0] A_OFS_VAL_HI = 8'h01;
    localparam logic [7:0] A_OFS_VAL_LO = 8'h02;

    // Main control bit positions
    localparam int B_OVF = 7;
    localparam int B_OIE = 6;
    localparam int B_HALT = 5;
    localparam int B_CLR = 4;
    localparam int B_PS_HI = 2;

    // Channel control bit positions
    localparam int B_FLAG = 7;
    localparam int B_IE = 6;
    localparam int B_BUF = 5;
    localparam int B_UNBUF = 4;
    localparam int B_ACT_HI = 3;
    localparam int B_ACT_LO = 2;
    localparam int B_TOV = 1;
    localparam int B_FULL = 0;

    // Reset values
    localparam logic HALT_RST = 1'b1;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [6:0] CFG_RST = 7'h00;
    localparam logic [7:0] ZERO8 = 8'h00;

    // Prescaler selection
    localparam logic [2:0] PS_EXT = 3'h7;
    localparam logic [5:0] DIV_ALL = 6'h3F;

    // Compare action, two-bit field
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR = 2'b10,
        ACT_SET = 2'b11
    } tpw_act_t;

    // Mode select, buffered bit over unbuffered bit
    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'b00,
        MODE_UNBUF = 2'b01,
        MODE_BUF = 2'b10,
        MODE_BUF_OVR = 2'b11
    } tpw_mode_t;

endpackage : tpw_pkg

// ---- tpw_prescale.sv ----
// Counter clock prescaler: internal divider or external clock edges
`timescale 1ns/1ps
module tpw_prescale (
    input wire logic clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic clr, // Clears divider
    input wire logic run, // Counter allowed to advance
    input wire logic [2:0] ps, // Prescale select
    input wire logic ext_rise, // Synchronised external clock edge
    output logic tick // One-cycle count enable
);

    logic [5:0] div;
    logic [5:0] mask;

    // Divider only advances while running, so stop freezes it too
    always_ff @(posedge clk) begin
        if (!reset_n || clr) begin
            div <= 6'h00;
        end else if (run) begin
            div <= div + 6'h01;
        end
    end

    // Mask of low ones selects divide by two to the ps
    always_comb begin
        mask = 6'(DIV_SHIFT(ps));
        if (ps == tpw_pkg::PS_EXT) begin
            tick = run & ext_rise;
        end else begin
            tick = run & ((div & mask) == mask);
        end
    end

    function automatic logic [5:0] DIV_SHIFT(input logic [2:0] s);
        DIV_SHIFT = ~(tpw_pkg::DIV_ALL << s);
    endfunction : DIV_SHIFT

endmodule : tpw_prescale

// ---- tpw_timer.sv ----
// Six-channel PWM timer with buffered channel pairs
// How it works
// RL1: Writing channel 5 while linked makes it govern width from next period.
// RL2: At each overflow a linked pair uses whichever channel was written last.
// RL3: Linked odd channel pin is released and its control register is unused.
// RL4: Software should not rewrite the active channel; that acts unbuffered.
// RL5: Software first halts the counter, then clears counter and prescaler.
// RL6: Software then loads the period modulo, then channel pulse widths.
// RL7: Mode field 0:1 selects unbuffered compare, 1:0 buffered compare.
// RL8: Software sets toggle-on-overflow so output inverts at each overflow.
// RL9: Action field 1:0 clears on compare, 1:1 sets on compare.
// RL10: Software should never use toggle on compare for PWM.
// RL11: Last step: software clears the halt bit to start counting.
// RL12: On even channels the buffered bit overrides the unbuffered bit.
// RL13: Linked even channel value starts first; its control reports the pair.
// RL14: With overflow toggle clear, output only changes by compare re-forcing.
// RL15: Full-duty bit with overflow toggle clear holds output at one.
// RL16: Overflow flag sets on rollover to zero; irq only when enabled.
// RL17: Channel flags set on capture or compare; irq only when enabled.
// RL18: In wait mode timer runs, registers inaccessible, irqs still raised.
// RL19: In stop mode timer and registers freeze, resuming afterwards.
// RL20: Break freezes the counter and blocks input captures.
// RL21: With break-clear enabled, flags cleared in break stay cleared.
// RL22: Otherwise break accesses leave flags; a pre-break armed clear completes after break.
// RL23: Period is overflow to overflow; width is overflow to compare match.
`timescale 1ns/1ps
module tpw_timer (
    input wire logic clk, // System clock, 125 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after strobe
    input wire logic ext_timer_clock, // External counter clock pin
    input wire logic [5:0] cap_in, // Channel pins as capture inputs
    output logic [5:0] ch_out, // Channel pin output level
    output logic [5:0] ch_oe, // Channel pin output enable
    input wire logic wait_mode, // Processor in wait mode
    input wire logic stop_mode, // Processor in stop mode
    input wire logic break_active, // Break state
    input wire logic break_clear_enable, // Flags clearable in break
    output logic ovf_irq, // Overflow interrupt request
    output logic [5:0] ch_irq // Channel interrupt requests
);

    localparam int N = tpw_pkg::NCH;

    logic [2:0] ext_sync;
    logic [5:0] cap_s1, cap_s2, cap_s3;
    logic wr_ok, rd_ok, clr_ok, run, tick, step, wrap, ovf_ev;
    logic ovf_flag, ovf_armed, ovf_irq_en, counter_halt, cnt_clr;
    logic [2:0] ps;
    logic [15:0] cnt, period_modulo, cmp_val [N];
    logic [7:0] mod_hi_buf, cnt_lo_hold;
    logic mod_pending, cnt_latched;
    logic [6:0] channel_ctrl [N];
    logic [15:0] channel_value [N];
    logic [7:0] val_hi_buf [N];
    logic [N-1:0] channel_event_flag, ch_armed, val_commit, cmp_ev, cap_ev;
    logic [N-1:0] out_mode;
    logic [tpw_pkg::NPAIR-1:0] pair_link, active_odd, last_odd;
    logic [7:0] next_rdata;

    // Registers shut off from the processor in wait mode [RL18]
    assign wr_ok = wr_en & ~wait_mode;
    assign rd_ok = rd_en & ~wait_mode;
    // Break protects flags unless clearing is allowed [RL21] [RL22]
    assign clr_ok = ~break_active | break_clear_enable;

    // Pin inputs pass two flops; third stage only for edge detect.
    // No reset: zeroing them would fake an edge on idle-high pins
    always_ff @(posedge clk) begin
        ext_sync <= {ext_sync[1:0], ext_timer_clock};
        cap_s1 <= cap_in;
        cap_s2 <= cap_s1;
        cap_s3 <= cap_s2;
    end

    // Halt, stop and break all freeze the count [RL19] [RL20]
    assign run = ~counter_halt & ~stop_mode & ~break_active;
    assign cnt_clr = wr_ok && addr == tpw_pkg::A_MAIN && wdata[tpw_pkg::B_CLR];

    tpw_prescale u_prescale (
        .clk(clk),
        .reset_n(reset_n),
        .clr(cnt_clr),
        .run(run),
        .ps(ps),
        .ext_rise(ext_sync[1] & ~ext_sync[2]),
        .tick(tick)
    );

    assign step = run & tick;
    // Rollover at the modulo value marks each period [RL23]
    assign wrap = step && cnt == period_modulo;
    // High-byte write of the modulo holds off the flag
    assign ovf_ev = wrap & ~mod_pending; // [RL16]

    // Counter, cleared by the write-only clear bit
    always_ff @(posedge clk) begin
        if (!reset_n || cnt_clr) begin
            cnt <= tpw_pkg::CNT_RST;
        end else if (wrap) begin
            cnt <= tpw_pkg::CNT_RST; // [RL16] [RL23]
        end else if (step) begin
            cnt <= cnt + 16'h0001;
        end
    end

    // Main control fields
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            counter_halt <= tpw_pkg::HALT_RST;
            ovf_irq_en <= 1'b0;
            ps <= 3'h0;
        end else if (wr_ok && addr == tpw_pkg::A_MAIN) begin
            counter_halt <= wdata[tpw_pkg::B_HALT];
            ovf_irq_en <= wdata[tpw_pkg::B_OIE];
            ps <= wdata[tpw_pkg::B_PS_HI:0];
        end
    end

    // Overflow flag, two-step clear; a new overflow wins over the clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ovf_flag <= 1'b0;
            ovf_armed <= 1'b0;
        end else if (ovf_ev) begin
            ovf_flag <= 1'b1; // [RL16]
            ovf_armed <= 1'b0;
        end else if (wr_ok && clr_ok && addr == tpw_pkg::A_MAIN
                     && ovf_armed && !wdata[tpw_pkg::B_OVF]) begin
            ovf_flag <= 1'b0; // [RL21] [RL22]
            ovf_armed <= 1'b0;
        end else if (rd_ok && clr_ok && addr == tpw_pkg::A_MAIN
                     && ovf_flag) begin
            ovf_armed <= 1'b1; // [RL22]
        end
    end

    // Modulo, committed as a whole word on the low byte
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            period_modulo <= tpw_pkg::MOD_RST;
            mod_hi_buf <= tpw_pkg::ZERO8;
            mod_pending <= 1'b0;
        end else if (wr_ok && addr == tpw_pkg::A_MOD_HI) begin
            mod_hi_buf <= wdata;
            mod_pending <= 1'b1;
        end else if (wr_ok && addr == tpw_pkg::A_MOD_LO) begin
            period_modulo <= {mod_hi_buf, wdata};
            mod_pending <= 1'b0;
        end
    end

    // Reading the count high byte latches the low byte for a clean pair
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_lo_hold <= tpw_pkg::ZERO8;
            cnt_latched <= 1'b0;
        end else if (rd_ok && addr == tpw_pkg::A_CNT_HI && !cnt_latched) begin
            cnt_lo_hold <= cnt[7:0];
            cnt_latched <= 1'b1;
        end else if (rd_ok && addr == tpw_pkg::A_CNT_LO) begin
            cnt_latched <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_ch
            localparam int P = gi / 2;
            localparam logic [7:0] A_CTL =
                8'(tpw_pkg::A_CH_BASE + tpw_pkg::A_CH_STRIDE * 8'(gi));
            localparam logic [7:0] A_VH = 8'(A_CTL + tpw_pkg::A_OFS_VAL_HI);
            localparam logic [7:0] A_VL = 8'(A_CTL + tpw_pkg::A_OFS_VAL_LO);
            logic odd_linked;
            logic [1:0] act;
            logic cap_edge;

            if (gi % 2 == 0) begin : g_even
                // Buffered bit alone decides linking [RL12]
                assign pair_link[P] = channel_ctrl[gi][tpw_pkg::B_BUF];
                assign odd_linked = 1'b0;
                // Active value of the pair; even one first [RL13] [RL1]
                assign cmp_val[gi] = (pair_link[P] && active_odd[P]) ?
                    channel_value[gi+1] : channel_value[gi];

                // Last-written member of a linked pair
                always_ff @(posedge clk) begin
                    if (!reset_n || !pair_link[P]) begin
                        last_odd[P] <= 1'b0;
                    end else if (val_commit[gi+1]) begin
                        last_odd[P] <= 1'b1; // [RL1]
                    end else if (val_commit[gi]) begin
                        last_odd[P] <= 1'b0; // [RL2]
                    end
                end

                // Switch source only at a period boundary
                always_ff @(posedge clk) begin
                    if (!reset_n || !pair_link[P]) begin
                        active_odd[P] <= 1'b0; // [RL13]
                    end else if (wrap) begin
                        active_odd[P] <= last_odd[P]; // [RL1] [RL2]
                    end
                end
            end else begin : g_odd
                // Odd member idle while its pair is linked [RL3]
                assign odd_linked = pair_link[P];
                assign cmp_val[gi] = channel_value[gi];
            end

            // Either mode bit selects compare output [RL7]
            assign out_mode[gi] = (channel_ctrl[gi][tpw_pkg::B_BUF]
                | channel_ctrl[gi][tpw_pkg::B_UNBUF]) & ~odd_linked;
            assign act = channel_ctrl[gi][tpw_pkg::B_ACT_HI:tpw_pkg::B_ACT_LO];
            assign cmp_ev[gi] = step & out_mode[gi] & (cnt == cmp_val[gi]);
            always_comb begin
                unique case (tpw_pkg::tpw_act_t'(act))
                    tpw_pkg::ACT_NONE: cap_edge = 1'b0;
                    tpw_pkg::ACT_TOGGLE: cap_edge = cap_s2[gi] & ~cap_s3[gi];
                    tpw_pkg::ACT_CLEAR: cap_edge = ~cap_s2[gi] & cap_s3[gi];
                    tpw_pkg::ACT_SET: cap_edge = cap_s2[gi] ^ cap_s3[gi];
                endcase
            end
            // Captures blocked by halt, stop and break [RL20]
            assign cap_ev[gi] = cap_edge & run & ~out_mode[gi] & ~odd_linked;
            // Pin released to port logic when not driving [RL3]
            assign ch_oe[gi] = out_mode[gi];
            assign ch_irq[gi] = channel_event_flag[gi]
                & channel_ctrl[gi][tpw_pkg::B_IE]; // [RL17] [RL18]

            // Channel control; odd control ignored while linked [RL3]
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    channel_ctrl[gi] <= tpw_pkg::CFG_RST;
                end else if (wr_ok && addr == A_CTL && !odd_linked) begin
                    channel_ctrl[gi] <= wdata[6:0];
                end
            end

            // Channel value, captured count or word written low-byte last
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    channel_value[gi] <= tpw_pkg::CNT_RST;
                    val_hi_buf[gi] <= tpw_pkg::ZERO8;
                end else if (cap_ev[gi]) begin
                    channel_value[gi] <= cnt;
                end else if (wr_ok && addr == A_VH) begin
                    val_hi_buf[gi] <= wdata;
                end else if (val_commit[gi]) begin
                    channel_value[gi] <= {val_hi_buf[gi], wdata};
                end
            end
            assign val_commit[gi] = wr_ok && addr == A_VL && !cap_ev[gi];

            // Event flag with two-step clear; set wins over clear
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    channel_event_flag[gi] <= 1'b0;
                    ch_armed[gi] <= 1'b0;
                end else if (cmp_ev[gi] || cap_ev[gi]) begin
                    channel_event_flag[gi] <= 1'b1; // [RL17]
                    ch_armed[gi] <= 1'b0;
                end else if (wr_ok && clr_ok && addr == A_CTL
                             && ch_armed[gi] && !wdata[tpw_pkg::B_FLAG]) begin
                    channel_event_flag[gi] <= 1'b0; // [RL21] [RL22]
                    ch_armed[gi] <= 1'b0;
                end else if (rd_ok && clr_ok && addr == A_CTL
                             && channel_event_flag[gi]) begin
                    ch_armed[gi] <= 1'b1; // [RL22]
                end
            end

            // Pin level: full duty, compare action, then overflow toggle
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    ch_out[gi] <= 1'b0;
                end else if (!channel_ctrl[gi][tpw_pkg::B_TOV]
                             && channel_ctrl[gi][tpw_pkg::B_FULL]) begin
                    ch_out[gi] <= 1'b1; // [RL15]
                end else if (cmp_ev[gi] && act == tpw_pkg::ACT_CLEAR) begin
                    ch_out[gi] <= 1'b0; // [RL9] [RL14]
                end else if (cmp_ev[gi] && act == tpw_pkg::ACT_SET) begin
                    ch_out[gi] <= 1'b1; // [RL9] [RL14]
                end else if (cmp_ev[gi] && act == tpw_pkg::ACT_TOGGLE) begin
                    ch_out[gi] <= ~ch_out[gi];
                end else if (wrap && out_mode[gi]
                             && channel_ctrl[gi][tpw_pkg::B_TOV]) begin
                    ch_out[gi] <= ~ch_out[gi]; // [RL14] [RL23]
                end
            end

            // Compare raises the flag on the next edge
            property p_ch_flag;
                @(posedge clk) disable iff (!reset_n)
                cmp_ev[gi] |=> channel_event_flag[gi];
            endproperty
            a_ch_flag: assert property (p_ch_flag) // [RL17]
                else $error("channel flag missed a compare");
        end
    endgenerate

    assign ovf_irq = ovf_flag & ovf_irq_en; // [RL16] [RL18]

    // Read mux; odd control reads zero while linked
    always_comb begin
        next_rdata = tpw_pkg::ZERO8;
        unique case (addr)
            tpw_pkg::A_MAIN: next_rdata = {ovf_flag, ovf_irq_en,
                counter_halt, 2'b00, ps};
            tpw_pkg::A_CNT_HI: next_rdata = cnt[15:8];
            tpw_pkg::A_CNT_LO: next_rdata = cnt_latched ?
                cnt_lo_hold : cnt[7:0];
            tpw_pkg::A_MOD_HI: next_rdata = period_modulo[15:8];
            tpw_pkg::A_MOD_LO: next_rdata = period_modulo[7:0];
            default: begin
                for (int i = 0; i < N; i++) begin
                    if (addr == 8'(tpw_pkg::A_CH_BASE
                        + tpw_pkg::A_CH_STRIDE * 8'(i))) begin
                        next_rdata = (i % 2 == 1 && pair_link[i/2]) ?
                            tpw_pkg::ZERO8 :
                            {channel_event_flag[i], channel_ctrl[i]};
                    end else if (addr == 8'(tpw_pkg::A_CH_BASE
                        + tpw_pkg::A_CH_STRIDE * 8'(i) + 8'h01)) begin
                        next_rdata = channel_value[i][15:8];
                    end else if (addr == 8'(tpw_pkg::A_CH_BASE
                        + tpw_pkg::A_CH_STRIDE * 8'(i) + 8'h02)) begin
                        next_rdata = channel_value[i][7:0];
                    end
                end
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata <= tpw_pkg::ZERO8;
        end else begin
            rdata <= rd_ok ? next_rdata : tpw_pkg::ZERO8;
        end
    end

    // Checks that guard the documented behaviour

    property p_ovf_set;
        @(posedge clk) disable iff (!reset_n)
        ovf_ev |=> ovf_flag && cnt == tpw_pkg::CNT_RST;
    endproperty
    a_ovf_set: assert property (p_ovf_set) // [RL16]
        else $error("overflow did not set flag and zero count");

    property p_ovf_irq;
        @(posedge clk) disable iff (!reset_n)
        ovf_irq |-> ovf_flag && ovf_irq_en;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) // [RL16]
        else $error("overflow irq without enable");

    property p_stop_freeze;
        @(posedge clk) disable iff (!reset_n)
        stop_mode && !cnt_clr |=> $stable(cnt);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) // [RL19]
        else $error("counter moved in stop mode");

    property p_break_freeze;
        @(posedge clk) disable iff (!reset_n)
        break_active && !cnt_clr |-> cap_ev == 6'h00 ##1 $stable(cnt);
    endproperty
    a_break_freeze: assert property (p_break_freeze) // [RL20]
        else $error("counter moved or capture in break");

    property p_break_protect;
        @(posedge clk) disable iff (!reset_n)
        break_active && !break_clear_enable |=> !$fell(ovf_flag)
            && !$fell(channel_event_flag[0]);
    endproperty
    a_break_protect: assert property (p_break_protect) // [RL22]
        else $error("flag cleared in protected break");

    property p_odd_release;
        @(posedge clk) disable iff (!reset_n)
        pair_link[2] |-> !ch_oe[5] && (!pair_link[1] || !ch_oe[3]);
    endproperty
    a_odd_release: assert property (p_odd_release) // [RL3] [RL12]
        else $error("linked odd pin still driven");

    property p_full_duty;
        @(posedge clk) disable iff (!reset_n)
        channel_ctrl[4][tpw_pkg::B_FULL] && !channel_ctrl[4][tpw_pkg::B_TOV]
            |=> ch_out[4];
    endproperty
    a_full_duty: assert property (p_full_duty) // [RL15]
        else $error("full duty output not high");

    property p_zero_duty;
        @(posedge clk) disable iff (!reset_n)
        !channel_ctrl[0][tpw_pkg::B_TOV] && !channel_ctrl[0][tpw_pkg::B_FULL]
            && !cmp_ev[0] |=> $stable(ch_out[0]);
    endproperty
    a_zero_duty: assert property (p_zero_duty) // [RL14]
        else $error("output changed without overflow toggle");

    sequence s_ch5_written;
        val_commit[5] && pair_link[2] && !wrap;
    endsequence

    sequence s_next_wrap;
        wrap && pair_link[2] && !val_commit[4];
    endsequence

    property p_ch5_takes;
        @(posedge clk) disable iff (!reset_n)
        s_ch5_written ##1 s_next_wrap |=> active_odd[2]
            && cmp_val[4] == channel_value[5];
    endproperty
    a_ch5_takes: assert property (p_ch5_takes) // [RL1] [RL2]
        else $error("channel 5 did not take over at overflow");

endmodule : tpw_timer

// ---- tpw_pin_load.sv ----
// Far-side load on one channel pin: measures period and high time
`timescale 1ns/1ps
module tpw_pin_load (
    input wire logic clk, // System clock
    input wire logic pin, // Observed pin level
    output logic [15:0] period, // Cycles between rising edges
    output logic [15:0] high // High cycles within that period
);
    logic prev;
    logic [15:0] cnt;
    logic [15:0] hcnt;
    // Restart both counts at each rising edge of the pin
    always_ff @(posedge clk) begin
        prev <= pin;
        if (pin && !prev) begin
            period <= cnt;
            high <= hcnt;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, pin};
        end
    end
endmodule : tpw_pin_load

// ---- test_tpw_timer.sv ----
// Self-checking bench for the six-channel PWM timer
`timescale 1ns/1ps
module test_tpw_timer;
    logic clk, reset_n, wr_en, rd_en, ovf_irq;
    logic wait_mode, stop_mode, break_active, break_clear_enable;
    logic ext_timer_clock;
    logic [7:0] addr, wdata, rdata, v, w;
    logic [5:0] ch_out, ch_oe, ch_irq, pins;
    logic [15:0] p0, h0, p4, h4;
    int failures, n_tests, cyc;
    // Released pins float high through a pull-up
    assign pins = (ch_oe & ch_out) | ~ch_oe;
    tpw_timer DUT (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_timer_clock(ext_timer_clock), .cap_in(pins),
        .ch_out(ch_out), .ch_oe(ch_oe), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_enable(break_clear_enable), .ovf_irq(ovf_irq),
        .ch_irq(ch_irq));
    tpw_pin_load L0 (.clk(clk), .pin(pins[0]), .period(p0), .high(h0));
    tpw_pin_load L4 (.clk(clk), .pin(pins[4]), .period(p4), .high(h4));
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic complete_run;
        $display("Tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Setup order: halt and clear, period, widths, modes, start
    task automatic pwm_setup;
        wr(8'h00, 8'h30);
        wr(8'h03, 8'h00);
        wr(8'h04, 8'h03);
        wr(8'h07, 8'h01);
        wr(8'h13, 8'h01);
        wr(8'h05, 8'h1A);
        wr(8'h11, 8'h3A);
        wr(8'h00, 8'h00);
        // Lands the channel 5 commit one cycle before an overflow
        repeat (19) @(posedge clk);
        check("period0", p0, 16'h0004);
        check("high0", h0, 16'h0002);
        check("high4", h4, 16'h0002);
        check("oe", {10'h000, ch_oe}, 16'h0011);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h02);
        repeat (20) @(posedge clk);
        check("high5", h4, 16'h0003);
    endtask : pwm_setup
    // Fixed duty levels and the channel event request
    task automatic duty_edges;
        wr(8'h05, 8'h18);
        repeat (9) @(posedge clk);
        check("zero", {15'h0000, ch_out[0]}, 16'h0000);
        wr(8'h05, 8'h19);
        repeat (9) @(posedge clk);
        check("full", {15'h0000, ch_out[0]}, 16'h0001);
        wr(8'h05, 8'h5A);
        repeat (9) @(posedge clk);
        check("chirq", {15'h0000, ch_irq[0]}, 16'h0001);
    endtask : duty_edges
    // Overflow request, break freezing and flag protection
    task automatic break_flags;
        wr(8'h00, 8'h40);
        repeat (9) @(posedge clk);
        check("ovfirq", {15'h0000, ovf_irq}, 16'h0001);
        break_active <= 1'b1;
        rd(8'h02, v);
        rd(8'h02, w);
        check("frozen", {8'h00, w}, {8'h00, v});
        rd(8'h00, v);
        wr(8'h00, 8'h40);
        #1;
        check("kept", {15'h0000, ovf_irq}, 16'h0001);
        break_clear_enable <= 1'b1;
        rd(8'h00, v);
        wr(8'h00, 8'h60);
        break_active <= 1'b0;
        repeat (4) @(posedge clk);
        check("cleared", {15'h0000, ovf_irq}, 16'h0000);
        wait_mode <= 1'b1;
        rd(8'h00, v);
        check("waitrd", {8'h00, v}, 16'h0000);
        wait_mode <= 1'b0;
        rd(8'h00, v);
        check("mainrd", {8'h00, v}, 16'h0060);
    endtask : break_flags
    // Stop freezes the count, which resumes afterwards
    task automatic stop_hold;
        wr(8'h00, 8'h40);
        stop_mode <= 1'b1;
        rd(8'h02, v);
        rd(8'h02, w);
        check("stopped", {8'h00, w}, {8'h00, v});
        stop_mode <= 1'b0;
        rd(8'h02, v);
        rd(8'h02, w);
        check("resumed", {8'h00, w}, {8'h00, (v + 8'h02) & 8'h03});
    endtask : stop_hold
    // Hang guard: far above the roughly 150 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {failures, n_tests, cyc} = '0;
        {reset_n, wr_en, rd_en, wait_mode, stop_mode} <= '0;
        {break_active, break_clear_enable, ext_timer_clock} <= '0;
        addr <= 8'h00;
        wdata <= 8'h00;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h00, v);
        check("main_rst", {8'h00, v}, 16'h0020);
        rd(8'h03, v);
        check("mod_rst", {8'h00, v}, 16'h00FF);
        pwm_setup();
        duty_edges();
        break_flags();
        stop_hold();
        complete_run();
    end
endmodule : test_tpw_timer
